// ===== adcfd_pkg.sv
package adcfd_pkg;

   // ---------------------------------------------------------------
   // setup word layout
   // ---------------------------------------------------------------
   localparam int CFG_W = 14;
   localparam int RES_W = 16;
   localparam int UPD_BIT = 13;
   localparam int CHAN_HI = 9;
   localparam int CHAN_LO = 7;
   localparam int BW_BIT = 6;
   localparam int REF_HI = 5;
   localparam int REF_LO = 3;
   localparam int SCAN_HI = 2;
   localparam int SCAN_LO = 1;
   localparam int ECHO_BIT = 0;
   // all-ones word is the preload a host gets by holding the data input high
   localparam logic [13:0] CFG_RST = 14'h3FFF;

   // ---------------------------------------------------------------
   // serial framing counts
   // ---------------------------------------------------------------
   localparam logic [3:0] CFG_BITS = 4'hE;
   localparam logic [4:0] EDGES_DATA = 5'h10;
   localparam logic [4:0] EDGES_ECHO = 5'h1E;

   // ---------------------------------------------------------------
   // reference field codes
   // ---------------------------------------------------------------
   localparam logic [2:0] REF_INT = 3'h1;
   localparam logic [2:0] REF_EXT_TS = 3'h2;
   localparam logic [2:0] REF_EXT_BUF_TS = 3'h3;
   localparam logic [2:0] REF_EXT_OFF = 3'h6;
   localparam logic [2:0] REF_EXT_BUF = 3'h7;

   typedef enum logic [1:0] {
      SCAN_OFF,
      SCAN_UPD,
      SCAN_TEMP,
      SCAN_LOOP
   } adcfd_scan_t;

   typedef struct packed {
      logic int_ref_en;
      logic ref_buf_en;
      logic temp_en;
      logic ext_ref_sel;
   } adcfd_refsel_t;

   function automatic adcfd_refsel_t adcfd_ref_decode(input logic [2:0] code);
      adcfd_refsel_t r;
      r = '{int_ref_en: 1'b0, ref_buf_en: 1'b0, temp_en: 1'b0, ext_ref_sel: 1'b1};
      unique case (code)
         REF_INT: r = '{1'b1, 1'b1, 1'b1, 1'b0};
         REF_EXT_TS: r = '{1'b0, 1'b0, 1'b1, 1'b1};
         REF_EXT_BUF_TS: r = '{1'b0, 1'b1, 1'b1, 1'b1};
         REF_EXT_OFF: r = '{1'b0, 1'b0, 1'b0, 1'b1};
         REF_EXT_BUF: r = '{1'b0, 1'b1, 1'b0, 1'b1};
         // reserved codes fall back to everything off, external reference
         default: r = '{1'b0, 1'b0, 1'b0, 1'b1};
      endcase
      // bandgap on always pulls the sensor on with it
      r.temp_en = r.temp_en | r.int_ref_en;
      return r;
   endfunction

endpackage

// ===== adcfd_shift_in.sv
`timescale 1ns/10ps
`default_nettype none

module adcfd_shift_in
   import adcfd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_frame,
   input wire logic i_sck_rise,
   input wire logic i_din,
   input wire logic i_clear,
   output logic [CFG_W-1:0] o_word,
   output logic o_full
);

   logic [CFG_W-1:0] word_r;
   logic [CFG_W-1:0] word_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;

   // ---------------------------------------------------------------
   // msb-first capture; bits past the fourteenth are ignored
   // ---------------------------------------------------------------
   always_comb begin
      word_nxt = word_r;
      cnt_nxt = cnt_r;
      if (i_clear) begin
         // an incomplete word is dropped at end of conversion
         cnt_nxt = 4'h0;
      end else if (i_frame && i_sck_rise && (cnt_r < CFG_BITS)) begin
         word_nxt = {word_r[CFG_W-2:0], i_din};
         cnt_nxt = cnt_r + 4'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         word_r <= 14'h0000;
         cnt_r <= 4'h0;
      end else begin
         word_r <= word_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign o_word = word_r;
   assign o_full = (cnt_r == CFG_BITS);

endmodule // adcfd_shift_in

`default_nettype wire

// ===== adcfd_scan_seq.sv
`timescale 1ns/10ps
`default_nettype none

module adcfd_scan_seq
   import adcfd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_eoc,
   input wire logic i_restart,
   input wire adcfd_scan_t i_mode,
   input wire logic [2:0] i_last,
   output logic [2:0] o_chan,
   output logic o_temp
);

   logic [2:0] pos_r;
   logic [2:0] pos_nxt;
   logic temp_r;
   logic temp_nxt;

   // ---------------------------------------------------------------
   // channel for the next conversion
   // ---------------------------------------------------------------
   always_comb begin
      pos_nxt = pos_r;
      temp_nxt = temp_r;
      if (i_mode == SCAN_OFF) begin
         pos_nxt = i_last;
         temp_nxt = 1'b0;
      end else if (i_restart) begin
         pos_nxt = 3'h0;
         temp_nxt = 1'b0;
      end else if (i_eoc) begin
         if (temp_r) begin
            pos_nxt = 3'h0;
            temp_nxt = 1'b0;
         end else if (pos_r >= i_last) begin
            pos_nxt = 3'h0;
            temp_nxt = (i_mode == SCAN_TEMP);
         end else begin
            pos_nxt = pos_r + 3'h1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pos_r <= 3'h0;
         temp_r <= 1'b0;
      end else begin
         pos_r <= pos_nxt;
         temp_r <= temp_nxt;
      end
   end

   assign o_chan = pos_r;
   assign o_temp = temp_r;

   chk_scan_wrap_loop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_mode == SCAN_LOOP && !i_restart && i_eoc && !temp_r && pos_r >= i_last)
      |=> (pos_r == 3'h0 && !temp_r))
      else $error("loop scan did not wrap to input 0");

   chk_scan_temp_slot: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_mode == SCAN_TEMP && !i_restart && i_eoc && !temp_r && pos_r >= i_last)
      |=> (temp_r && pos_r == 3'h0))
      else $error("temperature slot missing after last channel");

   chk_scan_temp_done: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_mode != SCAN_OFF && !i_restart && i_eoc && temp_r)
      |=> (!temp_r && pos_r == 3'h0))
      else $error("scan did not return to input 0 after temperature slot");

endmodule // adcfd_scan_seq

`default_nettype wire

// ===== adcfd_top.sv
`timescale 1ns/10ps
`default_nettype none

// Contract
// - bandwidth bit 1 gives full bandwidth; 0 switches in series resistor for quarter.
// - bandwidth limit is an analog series resistor, never digital sample processing.
// - reference code 001: internal reference, buffer and sensor on, 4.096 V out.
// - code 010: external reference, sensor on, internal buffer off.
// - code 011: external reference, buffer on, sensor on.
// - code 110: external reference; internal reference, buffer and sensor off.
// - code 111: external reference through buffer; internal reference and sensor off.
// - internal bandgap on always forces the temperature sensor on.
// - scan code 00 disables sequencer; 01 applies new setup during a running scan.
// - scan code 10 scans input 0 to channel field, then one temperature conversion.
// - scan code 11 repeats input 0 to channel field, no temperature conversion.
// - new fields replace the active setup only when the update bit is 1.
// - echo bit 1 disables setup readback; all-ones word gives no readback.
// - readback shifts setup msb first after result lsb, 30 falling edges total.
module adcfd_top
   import adcfd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_cnv,
   input wire logic i_sck,
   input wire logic i_din,
   input wire logic i_eoc,
   input wire logic [RES_W-1:0] i_result,
   output logic o_sdo,
   output logic o_sdo_oe,
   output logic [CFG_W-1:0] o_setup_word,
   output logic [2:0] o_channel_select,
   output logic o_filter_bandwidth_select,
   output logic o_series_res_en,
   output logic o_int_ref_en,
   output logic o_ref_buf_en,
   output logic o_temp_sensor_en,
   output logic o_ext_ref_sel,
   output logic [1:0] o_scan_mode,
   output logic o_setup_echo_disable,
   output logic [2:0] o_conv_channel,
   output logic o_conv_temp
);

   // ---------------------------------------------------------------
   // pin edges
   // ---------------------------------------------------------------
   logic cnv_q_r;
   logic sck_q_r;
   logic cnv_fall;
   logic cnv_rise;
   logic sck_rise;
   logic sck_fall;
   logic frame;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnv_q_r <= 1'b1;
         sck_q_r <= 1'b0;
      end else begin
         cnv_q_r <= i_cnv;
         sck_q_r <= i_sck;
      end
   end

   assign cnv_fall = cnv_q_r & ~i_cnv;
   assign cnv_rise = ~cnv_q_r & i_cnv;
   assign sck_rise = ~sck_q_r & i_sck;
   assign sck_fall = sck_q_r & ~i_sck;
   // data input is only listened to while the convert pin is low
   assign frame = ~i_cnv;

   // ---------------------------------------------------------------
   // incoming setup word
   // ---------------------------------------------------------------
   logic [CFG_W-1:0] in_word;
   logic in_full;

   adcfd_shift_in u_shift_in (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_frame(frame),
      .i_sck_rise(sck_rise),
      .i_din(i_din),
      .i_clear(i_eoc),
      .o_word(in_word),
      .o_full(in_full)
   );

   // ---------------------------------------------------------------
   // active setup, swapped only at end of conversion
   // ---------------------------------------------------------------
   logic [CFG_W-1:0] cfg_r;
   logic [CFG_W-1:0] cfg_nxt;
   logic take_word;
   logic seq_restart;

   assign take_word = i_eoc & in_full & in_word[UPD_BIT];

   always_comb begin
      cfg_nxt = cfg_r;
      if (take_word) begin
         cfg_nxt = in_word;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_r <= CFG_RST;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // a running scan survives a new word only when that word asks for it
   assign seq_restart = take_word &
      (adcfd_scan_t'(in_word[SCAN_HI:SCAN_LO]) != SCAN_UPD);

   // ---------------------------------------------------------------
   // decoded controls
   // ---------------------------------------------------------------
   adcfd_refsel_t ref_dec;
   adcfd_refsel_t ref_r;
   logic [2:0] chan_r;
   logic bw_r;
   logic res_r;
   logic [1:0] scan_r;
   logic echo_dis_r;

   // reserved codes are the host's to avoid; they decode to all-off here
   assign ref_dec = adcfd_ref_decode(cfg_r[REF_HI:REF_LO]);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ref_r <= '{1'b0, 1'b1, 1'b0, 1'b1};
         chan_r <= 3'h7;
         bw_r <= 1'b1;
         res_r <= 1'b0;
         scan_r <= 2'h3;
         echo_dis_r <= 1'b1;
      end else begin
         ref_r <= ref_dec;
         chan_r <= cfg_r[CHAN_HI:CHAN_LO];
         bw_r <= cfg_r[BW_BIT];
         // only the analog resistor switch sees this; samples are untouched
         res_r <= ~cfg_r[BW_BIT];
         scan_r <= cfg_r[SCAN_HI:SCAN_LO];
         echo_dis_r <= cfg_r[ECHO_BIT];
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   adcfd_scan_seq u_scan_seq (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_eoc(i_eoc),
      .i_restart(seq_restart),
      .i_mode(adcfd_scan_t'(cfg_nxt[SCAN_HI:SCAN_LO])),
      .i_last(cfg_nxt[CHAN_HI:CHAN_LO]),
      .o_chan(o_conv_channel),
      .o_temp(o_conv_temp)
   );

   // ---------------------------------------------------------------
   // result and setup readback
   // ---------------------------------------------------------------
   logic [RES_W+CFG_W-1:0] out_sh_r;
   logic [RES_W+CFG_W-1:0] out_sh_nxt;
   logic [4:0] out_cnt_r;
   logic [4:0] out_cnt_nxt;
   logic echo_r;
   logic echo_nxt;
   logic oe_r;
   logic oe_nxt;
   logic [4:0] out_limit;

   assign out_limit = echo_r ? EDGES_ECHO : EDGES_DATA;

   always_comb begin
      out_sh_nxt = out_sh_r;
      out_cnt_nxt = out_cnt_r;
      echo_nxt = echo_r;
      oe_nxt = oe_r;
      if (i_eoc) begin
         // the setup that governed this result travels with it; unread bits are lost
         out_sh_nxt = {i_result, cfg_r};
         echo_nxt = ~cfg_r[ECHO_BIT];
         out_cnt_nxt = 5'h00;
         oe_nxt = 1'b0;
      end else if (cnv_rise) begin
         oe_nxt = 1'b0;
      end else if (cnv_fall) begin
         oe_nxt = 1'b1;
         out_cnt_nxt = 5'h00;
      end else if (oe_r && sck_fall) begin
         out_sh_nxt = {out_sh_r[RES_W+CFG_W-2:0], 1'b0};
         out_cnt_nxt = out_cnt_r + 5'h01;
         if (out_cnt_nxt == out_limit) begin
            oe_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         out_sh_r <= 30'h0;
         out_cnt_r <= 5'h00;
         echo_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         out_sh_r <= out_sh_nxt;
         out_cnt_r <= out_cnt_nxt;
         echo_r <= echo_nxt;
         oe_r <= oe_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_sdo = out_sh_r[RES_W+CFG_W-1];
   assign o_sdo_oe = oe_r;
   assign o_setup_word = cfg_r;
   assign o_channel_select = chan_r;
   assign o_filter_bandwidth_select = bw_r;
   assign o_series_res_en = res_r;
   assign o_int_ref_en = ref_r.int_ref_en;
   assign o_ref_buf_en = ref_r.ref_buf_en;
   assign o_temp_sensor_en = ref_r.temp_en;
   assign o_ext_ref_sel = ref_r.ext_ref_sel;
   assign o_scan_mode = scan_r;
   assign o_setup_echo_disable = echo_dis_r;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_update_taken: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_eoc && in_full && in_word[UPD_BIT]) |=> (cfg_r == $past(in_word)))
      else $error("flagged full word not applied at end of conversion");

   chk_update_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !(i_eoc && in_full && in_word[UPD_BIT]) |=> (cfg_r == $past(cfg_r)))
      else $error("setup changed without a flagged full word");

   chk_bw_resistor: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ##1 (o_series_res_en == !o_filter_bandwidth_select)
      && (o_filter_bandwidth_select == $past(cfg_r[BW_BIT])))
      else $error("series resistor does not follow bandwidth bit");

   chk_ref_internal: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (cfg_r[REF_HI:REF_LO] == 3'h1) |=>
      (o_int_ref_en && o_ref_buf_en && o_temp_sensor_en && !o_ext_ref_sel))
      else $error("code 001 decode wrong");

   chk_ref_ext_sensor: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (cfg_r[REF_HI:REF_LO] == 3'h2) |=>
      (!o_int_ref_en && !o_ref_buf_en && o_temp_sensor_en && o_ext_ref_sel))
      else $error("code 010 decode wrong");

   chk_ref_ext_buf_ts: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (cfg_r[REF_HI:REF_LO] == 3'h3) |=>
      (!o_int_ref_en && o_ref_buf_en && o_temp_sensor_en && o_ext_ref_sel))
      else $error("code 011 decode wrong");

   chk_ref_all_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (cfg_r[REF_HI:REF_LO] == 3'h6) |=>
      (!o_int_ref_en && !o_ref_buf_en && !o_temp_sensor_en && o_ext_ref_sel))
      else $error("code 110 decode wrong");

   chk_ref_ext_buf: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (cfg_r[REF_HI:REF_LO] == 3'h7) |=>
      (!o_int_ref_en && o_ref_buf_en && !o_temp_sensor_en && o_ext_ref_sel))
      else $error("code 111 decode wrong");

   chk_bandgap_sensor: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_int_ref_en |-> o_temp_sensor_en)
      else $error("bandgap on with sensor off");

   chk_chan_binary: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ##1 (o_channel_select == $past(cfg_r[CHAN_HI:CHAN_LO])))
      else $error("channel select not binary field value");

   chk_out_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (oe_r && sck_fall && !i_eoc && !cnv_rise && !cnv_fall
      && out_cnt_r == (echo_r ? 5'h1D : 5'h0F)) |=> !o_sdo_oe)
      else $error("output not released after final falling edge");

   chk_echo_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_sdo_oe && !echo_r) |-> (out_cnt_r < 5'h10))
      else $error("readback bits sent while echo disabled");

   chk_echo_order: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_eoc |=> (out_sh_r == {$past(i_result), $past(cfg_r)}))
      else $error("result and setup not queued msb first");

endmodule // adcfd_top

`default_nettype wire

// ===== adcfd_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module adcfd_host_model (
   input wire logic i_clk,
   input wire logic i_sdo,
   input wire logic i_sdo_oe,
   output logic o_cnv,
   output logic o_sck,
   output logic o_din
);
   logic [29:0] rx;
   logic [29:0] oev;
   logic oe_end;

   initial begin
      o_cnv = 1'b1;
      o_sck = 1'b0;
      o_din = 1'b0;
      rx = '0;
      oev = '0;
      oe_end = 1'b0;
   end

   // ---------------------------------------------------------------
   // one access frame
   // ---------------------------------------------------------------
   // sck idles low; each level lasts two clocks so the sampled edge
   // detector inside the device never misses one
   task automatic xfer(input logic [13:0] w, input int nclk);
      @(negedge i_clk);
      o_cnv = 1'b0;
      repeat (3) @(negedge i_clk);
      for (int i = 0; i < nclk; i++) begin
         o_din = (i < 14) ? w[13 - i] : 1'b0;
         repeat (2) @(negedge i_clk);
         o_sck = 1'b1;
         repeat (2) @(negedge i_clk);
         rx = {rx[28:0], i_sdo};
         oev = {oev[28:0], i_sdo_oe};
         o_sck = 1'b0;
      end
      repeat (4) @(negedge i_clk);
      oe_end = i_sdo_oe;
      o_cnv = 1'b1;
      // released line shows the inverse so a stale level cannot pass
      o_din = ~o_din;
   endtask
endmodule // adcfd_host_model

`default_nettype wire

// ===== adc_config_field_decode_bench.sv
`timescale 1ns/10ps
`default_nettype none

module adc_config_field_decode_bench;
   import adcfd_pkg::*;
   logic clk;
   logic rst_n;
   logic eoc;
   logic [RES_W-1:0] result;
   wire logic cnv;
   wire logic sck;
   wire logic din;
   logic o_sdo, o_sdo_oe, o_filter_bandwidth_select, o_series_res_en;
   logic o_int_ref_en, o_ref_buf_en, o_temp_sensor_en, o_ext_ref_sel;
   logic o_setup_echo_disable, o_conv_temp;
   logic [CFG_W-1:0] o_setup_word;
   logic [2:0] o_channel_select, o_conv_channel;
   logic [1:0] o_scan_mode;
   logic [13:0] cur;
   int num_errors;
   int check_count;
   logic [2:0] ref_codes [5] = '{REF_INT, REF_EXT_TS, REF_EXT_BUF_TS, REF_EXT_OFF, REF_EXT_BUF};

   adcfd_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_cnv(cnv), .i_sck(sck), .i_din(din),
      .i_eoc(eoc), .i_result(result), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
      .o_setup_word(o_setup_word), .o_channel_select(o_channel_select),
      .o_filter_bandwidth_select(o_filter_bandwidth_select),
      .o_series_res_en(o_series_res_en), .o_int_ref_en(o_int_ref_en),
      .o_ref_buf_en(o_ref_buf_en), .o_temp_sensor_en(o_temp_sensor_en),
      .o_ext_ref_sel(o_ext_ref_sel), .o_scan_mode(o_scan_mode),
      .o_setup_echo_disable(o_setup_echo_disable), .o_conv_channel(o_conv_channel),
      .o_conv_temp(o_conv_temp));

   adcfd_host_model host (.i_clk(clk), .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe), .o_cnv(cnv),
      .o_sck(sck), .o_din(din));

   // ---------------------------------------------------------------
   // shared helpers
   // ---------------------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // {int_ref, buffer, sensor, ext_ref}
   function automatic logic [3:0] exp_ref(input logic [2:0] c);
      case (c)
         3'h1: return 4'hE;
         3'h2: return 4'h3;
         3'h3: return 4'h7;
         3'h6: return 4'h1;
         default: return 4'h5;
      endcase
   endfunction

   task automatic chk_dec(input logic [13:0] w);
      cmp(o_setup_word, w);
      cmp(o_channel_select, w[9:7]);
      cmp({o_filter_bandwidth_select, o_series_res_en}, {w[6], ~w[6]});
      cmp({o_int_ref_en, o_ref_buf_en, o_temp_sensor_en, o_ext_ref_sel}, exp_ref(w[5:3]));
      cmp(o_scan_mode, w[2:1]);
      cmp(o_setup_echo_disable, w[0]);
   endtask

   task automatic pulse_eoc(input logic [15:0] r);
      // quarter bandwidth: conversions are paced four times slower
      repeat (o_filter_bandwidth_select ? 2 : 8) @(negedge clk);
      eoc = 1'b1;
      result = r;
      @(negedge clk);
      eoc = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   task automatic load(input logic [13:0] w);
      host.xfer(w, 14);
      pulse_eoc(16'h0000);
      if (w[13]) cur = w;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_noecho();
      chk_dec(CFG_RST);
      cmp(o_sdo_oe, 1'b0);
      pulse_eoc(16'hC35A);
      host.xfer(14'h0000, 17);
      cmp(host.rx[16:1], 16'hC35A);
      cmp(host.oev[16:0], 17'h1FFFE);
      // the bit count only clears at end of conversion, so close this frame
      pulse_eoc(16'h0000);
      $display("noecho done");
   endtask

   task automatic t_codes();
      logic [13:0] w;
      for (int k = 0; k < 8; k++) begin
         w = {1'b1, 3'h7, 3'(k), k[0], ref_codes[k % 5], 2'h0, 1'b1};
         load(w);
         chk_dec(w);
         cmp(o_conv_channel, w[9:7]);
      end
      $display("codes done");
   endtask

   task automatic t_keep();
      load(14'h0E52);
      chk_dec(cur);
      host.xfer(14'h3C00, 10);
      pulse_eoc(16'h0000);
      chk_dec(cur);
      $display("keep done");
   endtask

   task automatic t_echo();
      load(14'h2A4E);
      pulse_eoc(16'hA5C3);
      host.xfer(14'h0000, 30);
      cmp(host.rx, {16'hA5C3, 14'h2A4E});
      cmp({host.oev, host.oe_end}, {30'h3FFFFFFF, 1'b0});
      pulse_eoc(16'h0000);
      $display("echo done");
   endtask

   task automatic t_seq();
      logic [1:0] m;
      int p;
      for (int j = 2; j < 4; j++) begin
         m = 2'(j);
         load({1'b1, 3'h7, 3'h2, 1'b1, REF_EXT_OFF, m, 1'b1});
         for (int s = 0; s < 6; s++) begin
            p = s % ((m == 2'h2) ? 4 : 3);
            if (p == 3) cmp(o_conv_temp, 1'b1);
            else cmp({o_conv_temp, o_conv_channel}, {1'b0, 3'(p)});
            pulse_eoc(16'h0000);
         end
      end
      load({1'b1, 3'h7, 3'h2, 1'b1, REF_EXT_OFF, 2'h1, 1'b1});
      chk_dec(cur);
      // scan was at input 0; the new word keeps it running, so it steps on
      cmp({o_conv_temp, o_conv_channel}, 4'h1);
      $display("seq done");
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      rst_n = 1'b0;
      eoc = 1'b0;
      result = '0;
      cur = CFG_RST;
      num_errors = 0;
      check_count = 0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_noecho();
      t_codes();
      t_keep();
      t_echo();
      t_seq();
      stop_test();
   end

   // the whole run needs under 1500 clocks; this is far beyond it
   initial begin
      #200000;
      num_errors++;
      stop_test();
   end
endmodule // adc_config_field_decode_bench

`default_nettype wire
